// file: dv/atas_axis_sva.sv
`timescale 1ns/1ps
// ******************
// Axis port checker
// ******************
module atas_axis_sva (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic drive_status,
  input wire logic home_switch,
  input wire logic drive_enable_cmd,
  input wire logic [1:0] analog_mode,
  input wire logic [1:0] status_mode,
  input wire logic [atas_pkg::TW-1:0] torque_limit,
  input wire logic err_clear,
  input wire logic drive_enable,
  input wire logic [atas_pkg::TW-1:0] torque_dac,
  input wire logic [atas_pkg::PW-1:0] actual_position,
  input wire logic axis_negative_of_home,
  input wire logic [11:0] error_code,
  input wire logic error_active,
  input wire logic torque_mode_active
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Signed views, one bit wider so the negated limit cannot wrap
  logic signed [16:0] tq;
  logic signed [16:0] lim;
  assign tq = {torque_dac[atas_pkg::TW-1], torque_dac};
  assign lim = {1'b0, torque_limit};
  chk_drive_pass: assert property (drive_enable == drive_enable_cmd)
    else $error("drive enable not passed on");
  chk_home_level: assert property (axis_negative_of_home == home_switch)
    else $error("home level wrong");
  chk_mode_flag: assert property (torque_mode_active == (analog_mode == 2'h1))
    else $error("torque mode flag wrong");
  chk_off_zero: assert property (!drive_enable_cmd [*2] |-> torque_dac == 16'h0000)
    else $error("torque while disabled");
  chk_gain_gate: assert property ((analog_mode != 2'h1) [*2] |-> torque_dac == 16'h0000)
    else $error("torque outside torque mode");
  chk_torque_clamp: assert property ($stable(torque_limit) |-> tq <= lim && tq >= -lim)
    else $error("torque above limit");
  chk_avail_fault: assert property ((status_mode == 2'h2 && drive_enable_cmd) [*3] ##0
    (!drive_status && error_code != atas_pkg::ERR_OUT_OF_SYNC)
    |-> ##[1:2] error_code == atas_pkg::ERR_SERVO_NOT_READY) else $error("status drop missed");
  chk_sup_off: assert property ((status_mode == 2'h0) [*3] ##0
    error_code != atas_pkg::ERR_SERVO_NOT_READY |=> error_code != atas_pkg::ERR_SERVO_NOT_READY)
    else $error("status error while unsupervised");
  chk_err_hold: assert property (error_code != 12'h000 && !err_clear |=> $stable(error_code))
    else $error("error code not held");
  chk_err_codes: assert property (error_code inside {12'h000, 12'h0c0, 12'h26d})
    else $error("illegal error code");
  chk_err_flag: assert property (error_active == (error_code != 12'h000))
    else $error("error flag wrong");
  chk_pos_quiet: assert property (($stable(enc_a) && $stable(enc_b)) [*5] |-> $stable(actual_position))
    else $error("position moved without edge");
  chk_pos_step: assert property ((actual_position - $past(actual_position))
    inside {32'h00000000, 32'h00000001, 32'hffffffff}) else $error("position step too big");
  // Main scenarios reached
  cover property (status_mode == 2'h2 ##1 error_code == atas_pkg::ERR_SERVO_NOT_READY);
  cover property (torque_dac != 16'h0000 && tq == lim);
  cover property (actual_position != $past(actual_position));
endmodule
bind atas_axis atas_axis_sva chk_u (.mclk, .sys_rst, .enc_a, .enc_b, .drive_status, .home_switch,
  .drive_enable_cmd, .analog_mode, .status_mode, .torque_limit, .err_clear, .drive_enable, .torque_dac,
  .actual_position, .axis_negative_of_home, .error_code, .error_active, .torque_mode_active);

// file: dv/atas_axis_tb.sv
`timescale 1ns/1ps
module atas_axis_tb;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic home_switch = 1'b0, drive_enable_cmd = 1'b0, forced_velocity_enable = 1'b0, err_clear = 1'b0;
  logic run = 1'b0, dir = 1'b0, sts_fault = 1'b0;
  logic [1:0] analog_mode = 2'h0, status_mode = 2'h0;
  logic [15:0] velocity_cmd = 16'h0000, forced_velocity_setpoint = 16'h0000, vel_kp = 16'h0000;
  logic [15:0] vel_ki = 16'h0000, torque_limit = 16'h7fff, max_velocity = 16'h7fff;
  logic [31:0] counts_per_rev = 32'h00000008;
  logic enc_a, enc_b, drive_status, drive_enable, axis_negative_of_home, error_active, torque_mode_active;
  logic [15:0] torque_dac, actual_velocity, t0;
  logic [31:0] actual_position, shaft_count, revolutions;
  logic [11:0] error_code;
  int mpos;
  int n_fail = 0;
  int tests_run = 0;
  // Rows: command, kp, limit, max velocity, forced setpoint, expected torque
  logic [15:0] tv [7][6] = '{'{16'h0064, 16'h0100, 16'h7fff, 16'h7fff, 16'h0000, 16'h0064},
    '{16'h0064, 16'h0200, 16'h7fff, 16'h7fff, 16'h0000, 16'h00c8},
    '{16'h0064, 16'h0100, 16'h0032, 16'h7fff, 16'h0000, 16'h0032},
    '{16'hff9c, 16'h0100, 16'h0032, 16'h7fff, 16'h0000, 16'hffce},
    '{16'h0064, 16'h0100, 16'h7fff, 16'h0014, 16'h0000, 16'h0014},
    '{16'h0064, 16'h0100, 16'h7fff, 16'h7fff, 16'h0000, 16'h0000},
    '{16'h0064, 16'h0100, 16'h7fff, 16'h7fff, 16'hffe2, 16'hffe2}};
  always #25 mclk = ~mclk;
  atas_axis dut_u (.mclk, .sys_rst, .enc_a, .enc_b, .drive_status, .home_switch, .drive_enable_cmd,
    .analog_mode, .status_mode, .velocity_cmd, .forced_velocity_enable, .forced_velocity_setpoint,
    .vel_kp, .vel_ki, .torque_limit, .max_velocity, .counts_per_rev, .err_clear, .drive_enable,
    .torque_dac, .actual_position, .actual_velocity, .shaft_count, .revolutions,
    .axis_negative_of_home, .error_code, .error_active, .torque_mode_active);
  atas_servo_model srv_u (.mclk, .drive_enable, .run, .dir, .sts_fault, .enc_a, .enc_b, .drive_status,
    .pos(mpos));
  task tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Watchdog: the sequence needs about 66400 cycles
  initial begin
    tick(100000);
    n_fail++;
    $display("BAD %0t watchdog expired", $time);
    end_of_test;
  end
  initial begin
    tick(3);
    sys_rst <= 1'b0;
    tick(2);
    cmp_word(torque_dac, 0, "reset torque");
    cmp_word(actual_position, 0, "reset position");
    cmp_word(torque_mode_active, 0, "reset mode");
    for (int i = 0; i < 2; i++) begin
      home_switch <= i[0];
      tick(2);
      cmp_word(axis_negative_of_home, i, "home level");
    end
    $display("test reset and home done");
    // Status drops while enabled: ignored unsupervised, caught in available mode
    drive_enable_cmd <= 1'b1;
    sts_fault <= 1'b1;
    tick(50);
    cmp_word(error_code, 0, "unsupervised");
    status_mode <= 2'h2;
    tick(5);
    cmp_word(error_code, 12'h0c0, "available drop");
    sts_fault <= 1'b0;
    status_mode <= 2'h1;
    tick(50);
    cmp_word(error_active, 1, "error latched");
    err_clear <= 1'b1;
    tick(1);
    err_clear <= 1'b0;
    drive_enable_cmd <= 1'b0;
    tick(100);
    drive_enable_cmd <= 1'b1;
    tick(100);
    cmp_word(error_code, 0, "ready in time");
    $display("test status done");
    // Regulator: gated by mode, then proportional, clamps and forced setpoint
    velocity_cmd <= 16'h0064;
    vel_kp <= 16'h0100;
    tick(4);
    cmp_word(torque_dac, 0, "velocity mode");
    analog_mode <= 2'h1;
    for (int i = 0; i < 7; i++) begin
      velocity_cmd <= tv[i][0];
      vel_kp <= tv[i][1];
      torque_limit <= tv[i][2];
      max_velocity <= tv[i][3];
      forced_velocity_setpoint <= tv[i][4];
      forced_velocity_enable <= (i >= 5);
      tick(4);
      cmp_word(torque_dac, tv[i][5], "torque row");
    end
    cmp_word(torque_mode_active, 1, "torque mode");
    // One velocity window adds the error once to the integrator
    forced_velocity_enable <= 1'b0;
    velocity_cmd <= 16'h000a;
    vel_kp <= 16'h0000;
    vel_ki <= 16'h0100;
    tick(4);
    t0 = torque_dac;
    tick(atas_pkg::VEL_WINDOW_CYC);
    cmp_word(torque_dac, t0 + 16'h000a, "integral step");
    drive_enable_cmd <= 1'b0;
    tick(3);
    cmp_word(torque_dac, 0, "disabled torque");
    $display("test regulator done");
    // Encoder forward then reverse; position tracks the model count
    status_mode <= 2'h0;
    run <= 1'b1;
    tick(1000);
    run <= 1'b0;
    tick(5);
    cmp_word(actual_position, mpos, "forward position");
    cmp_word(shaft_count, mpos % 8, "shaft count");
    cmp_word(revolutions, mpos / 8, "revolutions");
    dir <= 1'b1;
    run <= 1'b1;
    tick(45000);
    cmp_word(actual_velocity, 16'hfe70, "reverse velocity");
    run <= 1'b0;
    tick(5);
    cmp_word(actual_position, mpos, "reverse position");
    $display("test encoder done");
    end_of_test;
  end
endmodule

// file: dv/atas_servo_model.sv
`timescale 1ns/1ps
// ***********************
// Amplifier and encoder
// ***********************
module atas_servo_model #(
  parameter int STEP_CYC = 50,
  parameter int STS_DELAY = 20
) (
  input wire logic mclk,
  input wire logic drive_enable,
  input wire logic run,
  input wire logic dir,
  input wire logic sts_fault,
  output logic enc_a,
  output logic enc_b,
  output logic drive_status,
  output int pos
);
  logic [1:0] ph = 2'h0;
  logic st = 1'b0;
  int div = 0;
  int sc = 0;
  // Gray phase: forward runs 00,10,11,01 so A leads B
  assign enc_a = ph[1] ^ ph[0];
  assign enc_b = ph[1];
  // Fault drops status even while enabled, to provoke the supervisor
  assign drive_status = st & !sts_fault;
  initial pos = 0;
  // Fixed step rate keeps edge counts per window exact
  always @(posedge mclk) begin
    if (run) begin
      div <= (div == STEP_CYC - 1) ? 0 : div + 1;
      if (div == STEP_CYC - 1) begin
        ph <= dir ? ph - 2'h1 : ph + 2'h1;
        pos <= dir ? pos - 1 : pos + 1;
      end
    end
  end
  // Status follows enable both ways, well inside the deadline
  always @(posedge mclk) begin
    sc <= (drive_enable != st) ? sc + 1 : 0;
    if (sc == STS_DELAY) begin
      st <= drive_enable;
    end
  end
endmodule

// file: hw/atas_axis.sv
`timescale 1ns/1ps
// Summary of operation
// - Ready mode: status must follow enable both ways within 500 ms, else error.
// - Available mode: status dropping while enable is on raises an error.
// - Status supervision can be disabled; then no status error ever.
// - Status supervision failure reports code 0x0c0, servo not ready.
// - Commanded motion without tracking feedback reports code 0x26d, out of sync.
// - Proportional term is velocity error times proportional gain.
// - Integral term is accumulated velocity error times integral gain.
// - Velocity gains act only in torque mode, ignored otherwise.
// - Torque command magnitude clamped to configured torque limit.
// - Velocity command clamped to maximum system velocity.
// - Home input high means axis is on the negative side of home.
// - Forced velocity setpoint drives loop directly; zero holds motor still.
// - Velocity sign follows A/B phase order; swapping channels inverts it.
// - One revolution advances position by configured counts per revolution.
// - Torque mode is selectable, never the reset default.
// - Output is bipolar plus or minus 10 V full scale, sign gives direction.
module atas_axis (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic drive_status,
  input wire logic home_switch,
  input wire logic drive_enable_cmd,
  input wire logic [1:0] analog_mode,
  input wire logic [1:0] status_mode,
  input wire logic [atas_pkg::VW-1:0] velocity_cmd,
  input wire logic forced_velocity_enable,
  input wire logic [atas_pkg::VW-1:0] forced_velocity_setpoint,
  input wire logic [atas_pkg::GW-1:0] vel_kp,
  input wire logic [atas_pkg::GW-1:0] vel_ki,
  input wire logic [atas_pkg::TW-1:0] torque_limit,
  input wire logic [atas_pkg::VW-1:0] max_velocity,
  input wire logic [atas_pkg::PW-1:0] counts_per_rev,
  input wire logic err_clear,
  output logic drive_enable,
  output logic [atas_pkg::TW-1:0] torque_dac,
  output logic [atas_pkg::PW-1:0] actual_position,
  output logic [atas_pkg::VW-1:0] actual_velocity,
  output logic [atas_pkg::PW-1:0] shaft_count,
  output logic [atas_pkg::PW-1:0] revolutions,
  output logic axis_negative_of_home,
  output logic [11:0] error_code,
  output logic error_active,
  output logic torque_mode_active
);
  // ***********************************************
  // Helpers
  // ***********************************************
  // Symmetric clamp of a signed value to +/- limit
  function automatic logic signed [atas_pkg::AW-1:0] clamp_s(input logic signed [atas_pkg::AW-1:0] v,
                                                             input logic [atas_pkg::TW-1:0] lim);
    logic signed [atas_pkg::AW-1:0] l;
    l = $signed({{(atas_pkg::AW-atas_pkg::TW){1'b0}}, lim});
    if (v > l) begin
      clamp_s = l;
    end else if (v < -l) begin
      clamp_s = -l;
    end else begin
      clamp_s = v;
    end
  endfunction
  function automatic logic signed [atas_pkg::AW-1:0] sext_v(input logic [atas_pkg::VW-1:0] v);
    sext_v = {{(atas_pkg::AW-atas_pkg::VW){v[atas_pkg::VW-1]}}, v};
  endfunction

  // ***********************************************
  // Feedback
  // ***********************************************
  atas_qd_if qd();
  atas_quad_decoder u_dec (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .enc_a(enc_a),
    .enc_b(enc_b),
    .qd(qd)
  );
  assign actual_position = qd.position;
  assign actual_velocity = qd.velocity;

  // Revolution counter, modulo configured counts; avoids a divider
  logic [atas_pkg::PW-1:0] shaft;
  logic [atas_pkg::PW-1:0] revs;
  wire [atas_pkg::PW-1:0] cpr_m1 = counts_per_rev - 32'h00000001;
  logic [atas_pkg::PW-1:0] last_pos;
  wire pos_up = qd.cnt_event & ($signed(qd.position - last_pos) > 0);
  wire pos_dn = qd.cnt_event & ($signed(qd.position - last_pos) < 0);
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      shaft <= 32'h00000000;
      revs <= 32'h00000000;
      last_pos <= 32'h00000000;
    end else begin
      last_pos <= qd.position;
      if (pos_up) begin
        shaft <= (shaft >= cpr_m1) ? 32'h00000000 : shaft + 32'h00000001;
        revs <= (shaft >= cpr_m1) ? revs + 32'h00000001 : revs;
      end else if (pos_dn) begin
        shaft <= (shaft == 32'h00000000) ? cpr_m1 : shaft - 32'h00000001;
        revs <= (shaft == 32'h00000000) ? revs - 32'h00000001 : revs;
      end
    end
  end
  assign shaft_count = shaft;
  assign revolutions = revs;

  // Home polarity: asserted means negative side
  assign axis_negative_of_home = home_switch;

  // ***********************************************
  // Mode and velocity command
  // ***********************************************
  wire torque_mode = (analog_mode == atas_pkg::ATAS_MODE_TORQUE);
  assign torque_mode_active = torque_mode;
  assign drive_enable = drive_enable_cmd;
  // Forced setpoint bypasses the outer command
  wire [atas_pkg::VW-1:0] vsel = forced_velocity_enable ? forced_velocity_setpoint : velocity_cmd;
  wire signed [atas_pkg::AW-1:0] vcmd = clamp_s(sext_v(vsel), max_velocity);
  wire signed [atas_pkg::AW-1:0] verr = vcmd - sext_v(qd.velocity);

  // ***********************************************
  // Velocity PI regulator
  // ***********************************************
  logic signed [atas_pkg::IW-1:0] integ;
  logic clamped;
  wire signed [atas_pkg::AW-1:0] kp_s = $signed({{(atas_pkg::AW-atas_pkg::GW){1'b0}}, vel_kp});
  wire signed [atas_pkg::AW-1:0] ki_s = $signed({{(atas_pkg::AW-atas_pkg::GW){1'b0}}, vel_ki});
  wire signed [atas_pkg::AW-1:0] integ_x = {{(atas_pkg::AW-atas_pkg::IW){integ[atas_pkg::IW-1]}}, integ};
  wire signed [atas_pkg::AW-1:0] p_term = (verr * kp_s) >>> atas_pkg::GAIN_SHIFT;
  wire signed [atas_pkg::AW-1:0] i_term = (integ_x * ki_s) >>> atas_pkg::GAIN_SHIFT;
  wire signed [atas_pkg::AW-1:0] pi_sum = p_term + i_term;
  wire [atas_pkg::TW-1:0] lim_eff = (torque_limit > atas_pkg::DAC_FULL_SCALE) ? atas_pkg::DAC_FULL_SCALE
                                                                            : torque_limit;
  wire signed [atas_pkg::AW-1:0] pi_lim = clamp_s(pi_sum, lim_eff);
  wire sat = (pi_lim != pi_sum);
  // Anti-windup: freeze while saturated; zero gain stops accumulation too
  wire integ_run = drive_enable_cmd & torque_mode & (vel_ki != 16'h0000) & ~clamped;
  wire signed [atas_pkg::AW-1:0] integ_sum = integ_x + verr;
  wire signed [atas_pkg::AW-1:0] integ_next = clamp_s(integ_sum, 16'hffff);
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      integ <= 32'h00000000;
      clamped <= 1'b0;
      torque_dac <= 16'h0000;
    end else begin
      clamped <= sat;
      if (!drive_enable_cmd || !torque_mode) begin
        integ <= 32'h00000000;
      end else if (qd.vel_strobe && integ_run) begin
        integ <= integ_next[atas_pkg::IW-1:0];
      end
      // Zero torque when disabled or not in torque mode; signed code spans +/-10 V
      if (drive_enable_cmd && torque_mode) begin
        torque_dac <= pi_lim[atas_pkg::TW-1:0];
      end else begin
        torque_dac <= 16'h0000;
      end
    end
  end

  // ***********************************************
  // Drive status supervision
  // ***********************************************
  atas_pkg::atas_sv_state_t sv_state;
  atas_pkg::atas_sv_state_t next_sv_state;
  logic [31:0] sv_tmr;
  logic en_q;
  logic sts_fault;
  wire sv_deadline = (sv_tmr == 32'(atas_pkg::STATUS_DEADLINE_CYC - 1));
  wire en_edge = drive_enable_cmd ^ en_q;
  wire mode_ready = (status_mode == atas_pkg::ATAS_STS_READY);
  wire mode_avail = (status_mode == atas_pkg::ATAS_STS_AVAILABLE);
  // State decode for ready mode deadline tracking
  always_comb begin
    next_sv_state = sv_state;
    case (sv_state)
      atas_pkg::ATAS_SV_IDLE: begin
        if (en_edge) begin
          next_sv_state = atas_pkg::ATAS_SV_WAIT;
        end
      end
      atas_pkg::ATAS_SV_WAIT: begin
        if (en_edge) begin
          next_sv_state = atas_pkg::ATAS_SV_WAIT;
        end else if (drive_status == drive_enable_cmd || sv_deadline) begin
          next_sv_state = atas_pkg::ATAS_SV_ON;
        end
      end
      atas_pkg::ATAS_SV_ON: begin
        if (en_edge) begin
          next_sv_state = atas_pkg::ATAS_SV_WAIT;
        end
      end
      default: next_sv_state = atas_pkg::ATAS_SV_IDLE;
    endcase
  end
  always_comb begin
    sts_fault = 1'b0;
    if (mode_ready) begin
      sts_fault = (sv_state == atas_pkg::ATAS_SV_WAIT) & ~en_edge & sv_deadline &
                  (drive_status != drive_enable_cmd);
    end else if (mode_avail) begin
      sts_fault = drive_enable_cmd & en_q & ~drive_status;
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sv_state <= atas_pkg::ATAS_SV_IDLE;
      sv_tmr <= 32'h00000000;
      en_q <= 1'b0;
    end else begin
      en_q <= drive_enable_cmd;
      sv_state <= next_sv_state;
      sv_tmr <= (en_edge || sv_state != atas_pkg::ATAS_SV_WAIT) ? 32'h00000000 : sv_tmr + 32'h00000001;
    end
  end

  // ***********************************************
  // Out-of-sync watch
  // ***********************************************
  // Moving command but no encoder edge for a whole window
  logic [31:0] sync_tmr;
  wire vmag_big = (vcmd > atas_pkg::SYNC_MIN_CMD) || (vcmd < -atas_pkg::SYNC_MIN_CMD);
  wire moving_cmd = drive_enable_cmd & vmag_big;
  wire sync_fault = moving_cmd & (sync_tmr == 32'(atas_pkg::SYNC_WINDOW_CYC - 1));
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sync_tmr <= 32'h00000000;
    end else if (!moving_cmd || qd.cnt_event || sync_fault) begin
      sync_tmr <= 32'h00000000;
    end else begin
      sync_tmr <= sync_tmr + 32'h00000001;
    end
  end

  // ***********************************************
  // Error latch
  // ***********************************************
  // First error holds; a new fault in the clear cycle wins over the clear
  wire sts_err = sts_fault & (status_mode != atas_pkg::ATAS_STS_DISABLED);
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      error_code <= atas_pkg::ERR_NONE;
    end else if (sts_err && (error_code == atas_pkg::ERR_NONE || err_clear)) begin
      error_code <= atas_pkg::ERR_SERVO_NOT_READY;
    end else if (sync_fault && (error_code == atas_pkg::ERR_NONE || err_clear)) begin
      error_code <= atas_pkg::ERR_OUT_OF_SYNC;
    end else if (err_clear) begin
      error_code <= atas_pkg::ERR_NONE;
    end
  end
  assign error_active = (error_code != atas_pkg::ERR_NONE);
endmodule

// file: hw/atas_pkg.sv
package atas_pkg;
  // ***********************************************
  // Clock and timing
  // ***********************************************
  localparam int CLK_HZ = 20000000;
  localparam int STATUS_DEADLINE_MS = 500;
  localparam int STATUS_DEADLINE_CYC = (CLK_HZ / 1000) * STATUS_DEADLINE_MS;
  localparam int VEL_WINDOW_US = 1000;
  localparam int VEL_WINDOW_CYC = (CLK_HZ / 1000000) * VEL_WINDOW_US;
  localparam int SYNC_WINDOW_MS = 100;
  localparam int SYNC_WINDOW_CYC = (CLK_HZ / 1000) * SYNC_WINDOW_MS;
  // ***********************************************
  // Widths
  // ***********************************************
  localparam int VW = 16;
  localparam int PW = 32;
  localparam int GW = 16;
  localparam int TW = 16;
  localparam int IW = 32;
  localparam int AW = 48;
  localparam int GAIN_SHIFT = 8;
  localparam int SYNC_MIN_CMD = 4;
  localparam logic [TW-1:0] DAC_FULL_SCALE = 16'h7fff;
  // ***********************************************
  // Error codes
  // ***********************************************
  localparam logic [11:0] ERR_NONE = 12'h000;
  localparam logic [11:0] ERR_SERVO_NOT_READY = 12'h0c0;
  localparam logic [11:0] ERR_OUT_OF_SYNC = 12'h26d;
  // ***********************************************
  // Modes
  // ***********************************************
  typedef enum logic [1:0] {
    ATAS_MODE_VELOCITY = 2'h0,
    ATAS_MODE_TORQUE = 2'h1,
    ATAS_MODE_OTHER = 2'h2
  } atas_mode_t;
  typedef enum logic [1:0] {
    ATAS_STS_DISABLED = 2'h0,
    ATAS_STS_READY = 2'h1,
    ATAS_STS_AVAILABLE = 2'h2
  } atas_sts_mode_t;
  typedef enum logic [2:0] {
    ATAS_SV_IDLE = 3'b001,
    ATAS_SV_WAIT = 3'b010,
    ATAS_SV_ON = 3'b100
  } atas_sv_state_t;
endpackage

// file: hw/atas_qd_if.sv
`timescale 1ns/1ps
interface atas_qd_if;
  logic [atas_pkg::VW-1:0] velocity;
  logic vel_strobe;
  logic [atas_pkg::PW-1:0] position;
  logic cnt_event;
  modport dec(output velocity, output vel_strobe, output position, output cnt_event);
  modport use_side(input velocity, input vel_strobe, input position, input cnt_event);
endinterface

// file: hw/atas_quad_decoder.sv
`timescale 1ns/1ps
module atas_quad_decoder (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic enc_a,
  input wire logic enc_b,
  atas_qd_if.dec qd
);
  logic a_q;
  logic b_q;
  logic [atas_pkg::VW-1:0] win_cnt;
  logic [31:0] win_tmr;
  // Direction from phase order: A leading B counts up
  wire moved = (enc_a ^ a_q) | (enc_b ^ b_q);
  wire dir_up = enc_a ^ b_q;
  wire win_end = (win_tmr == 32'(atas_pkg::VEL_WINDOW_CYC - 1));
  wire [atas_pkg::VW-1:0] step = dir_up ? 16'h0001 : 16'hffff;
  // ***********************************************
  // Edge counting and velocity windows
  // ***********************************************
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      win_cnt <= 16'h0000;
      win_tmr <= 32'h00000000;
      qd.velocity <= 16'h0000;
      qd.vel_strobe <= 1'b0;
      qd.position <= 32'h00000000;
      qd.cnt_event <= 1'b0;
    end else begin
      a_q <= enc_a;
      b_q <= enc_b;
      qd.cnt_event <= moved;
      qd.vel_strobe <= win_end;
      if (moved) begin
        qd.position <= qd.position + {{(atas_pkg::PW-atas_pkg::VW){step[15]}}, step};
      end
      if (win_end) begin
        win_tmr <= 32'h00000000;
        qd.velocity <= moved ? win_cnt + step : win_cnt;
        win_cnt <= 16'h0000;
      end else begin
        win_tmr <= win_tmr + 32'h00000001;
        win_cnt <= moved ? win_cnt + step : win_cnt;
      end
    end
  end
endmodule
